// >>> hdl/ntac_core.sv
/*
 NT-side activation criteria: decodes local commands, pins and test bits,
 watches line events and runs the supervisory timers.
 Assumes all inputs synchronous to core_clk; line detectors outside.
*/
`timescale 1ns/1ps
module ntac_core #(
	parameter int unsigned TICK_CYCLES  = ntac_pkg::TICK_CYCLES,
	parameter int unsigned STARTUP_TICKS = ntac_pkg::STARTUP_TICKS,
	parameter int unsigned ECHO_TICKS   = ntac_pkg::ECHO_TICKS,
	parameter int unsigned FSYNC_TICKS  = ntac_pkg::FSYNC_TICKS,
	parameter int unsigned LONG_TICKS   = ntac_pkg::LONG_TICKS,
	parameter int unsigned FRAME_TICKS  = ntac_pkg::FRAME_TICKS
) (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] cmd_code,
	input  wire logic       cmd_valid,
	input  wire logic       data_in_pin,
	input  wire logic       reset_pin_n,
	input  wire logic       pulse_test_pin,
	input  wire logic       up_mode,
	input  wire logic       soft_wake_bit,
	input  wire logic       test_select_low,
	input  wire logic       test_select_high,
	input  wire logic       far_transparent_bit,
	input  wire logic       teardown_bit,
	input  wire logic       line_only_bit,
	input  wire logic       line_signal,
	input  wire logic       frame_ok,
	input  wire logic       poor_sync,
	input  wire logic       tone_period,
	input  wire logic       fill_bit_valid,
	input  wire logic       fill_bit,
	input  wire logic       echo_converged,
	input  wire logic       expect_silence,
	output logic            tx_transparent_bit,
	output logic            tx_open,
	output logic            rx_open,
	output logic            network_wake_tone,
	output logic            echo_training_signal,
	output logic            analog_loop,
	output logic            single_pulse_out,
	output logic            core_clear,
	output logic            iface_clocks_on,
	output logic            s_side_enable,
	output logic [3:0]      ind_code,
	output logic            frame_loss,
	output logic            short_signal_loss,
	output logic            long_signal_loss,
	output logic            exchange_wake_tone,
	output logic            fill_pattern_detect_zero,
	output logic            fill_pattern_detect_one,
	output logic            startup_guard_expired,
	output logic            echo_guard_expired,
	output logic            fsync_expired,
	output logic            rxrst_done,
	output logic            tone_done,
	output logic            pend_done
);
	ntac_pkg::ntac_state_type state;
	ntac_pkg::ntac_state_type next_state;

	logic [15:0] tick_div;
	logic        tick;
	logic [15:0] frame_cnt;
	logic [15:0] short_cnt;
	logic [3:0]  tone_cnt;
	logic [15:0] fill_cnt;
	logic        fill_last;
	logic [15:0] pulse_cnt;
	logic [7:0]  pulse_w;
	logic        loop_req;
	logic        short_run;
	logic        long_done;
	logic        long_signal_loss_arm;

	wire cmd_is  = cmd_valid;
	wire c_act   = cmd_is && cmd_code == ntac_pkg::CODE_ACT_REQ;
	wire c_loop  = cmd_is && cmd_code == ntac_pkg::CODE_LOCAL_LOOP;
	wire c_dt    = cmd_is && cmd_code == ntac_pkg::CODE_DATA_THRU;
	wire c_sync  = cmd_is && cmd_code == ntac_pkg::CODE_S_SYNC;
	wire c_err   = cmd_is && cmd_code == ntac_pkg::CODE_S_ERROR;
	wire c_clr   = cmd_is && cmd_code == ntac_pkg::CODE_CORE_CLEAR;
	wire c_sp    = cmd_is && cmd_code == ntac_pkg::CODE_SINGLE_PULSE;
	wire c_idle  = cmd_is && cmd_code == ntac_pkg::CODE_IDLE_DEACT;
	wire c_keep  = cmd_is && cmd_code != ntac_pkg::CODE_IDLE_DEACT;

	// Pin tests only in stand-alone mode; select bits only under processor
	wire [1:0] tsel    = {test_select_high, test_select_low};
	wire pin_rst       = !reset_pin_n && !(!up_mode && pulse_test_pin);
	wire pin_sp        = !up_mode && pulse_test_pin && reset_pin_n;
	wire pin_dt        = !up_mode && pulse_test_pin && !reset_pin_n;
	wire up_sp         = up_mode && tsel == ntac_pkg::TSEL_SINGLE_PULSE;
	wire up_dt         = up_mode && tsel == ntac_pkg::TSEL_DATA_THRU;
	wire pin_any       = !reset_pin_n || pin_sp || pin_dt;
	wire do_clear      = pin_rst || (c_clr && !pin_any);
	wire do_sp         = pin_sp || up_sp || (c_sp && !pin_any);
	wire do_dt         = pin_dt || up_dt || (c_dt && !pin_any);
	wire data_eff      = (up_mode && !soft_wake_bit) ? 1'b0 : data_in_pin;
	wire wake_req      = !data_eff;
	wire tick_wrap     = tick_div == 16'(TICK_CYCLES - 1);
	wire t1_start      = state == ntac_pkg::NTAC_TONE && next_state == ntac_pkg::NTAC_TRAIN && !loop_req;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_div <= 16'h0000;
			tick     <= 1'b0;
		end
		else
		begin
			tick_div <= tick_wrap ? 16'h0000 : tick_div + 16'h0001;
			tick     <= tick_wrap;
		end
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			ntac_pkg::NTAC_IDLE:
				if (wake_req || c_keep)
					next_state = ntac_pkg::NTAC_AWAKE;
			ntac_pkg::NTAC_AWAKE:
				if (c_idle)
					next_state = ntac_pkg::NTAC_PEND;
				else if (c_act || exchange_wake_tone)
					next_state = ntac_pkg::NTAC_TONE;
				else if (c_loop)
					next_state = ntac_pkg::NTAC_TRAIN;
			ntac_pkg::NTAC_TONE:
				if (tone_done)
					next_state = ntac_pkg::NTAC_TRAIN;
			ntac_pkg::NTAC_TRAIN:
				if (fill_pattern_detect_zero || fill_pattern_detect_one)
					next_state = ntac_pkg::NTAC_ACTIVE;
				else if (startup_guard_expired || (loop_req && !c_loop))
					next_state = ntac_pkg::NTAC_AWAKE;
			ntac_pkg::NTAC_ACTIVE:
				if (!teardown_bit || long_signal_loss || frame_loss)
					next_state = ntac_pkg::NTAC_AWAKE;
				else if (loop_req && !c_loop)
					next_state = ntac_pkg::NTAC_AWAKE;
			ntac_pkg::NTAC_TEST:
				if (!do_sp && !do_dt && !do_clear && reset_pin_n && c_idle)
					next_state = ntac_pkg::NTAC_PEND;
			ntac_pkg::NTAC_PEND:
				if (pend_done)
					next_state = ntac_pkg::NTAC_IDLE;
			default:
				next_state = ntac_pkg::NTAC_IDLE;
		endcase
		if (do_clear || do_sp || do_dt)
			next_state = ntac_pkg::NTAC_TEST;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= ntac_pkg::NTAC_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			loop_req             <= 1'b0;
			tx_transparent_bit   <= 1'b0;
			tx_open              <= 1'b0;
			rx_open              <= 1'b0;
			network_wake_tone    <= 1'b0;
			echo_training_signal <= 1'b0;
			analog_loop          <= 1'b0;
			core_clear           <= 1'b0;
			iface_clocks_on      <= 1'b0;
			s_side_enable        <= 1'b0;
			ind_code             <= ntac_pkg::MSG_POWER_DOWN;
		end
		else
		begin
			if (state == ntac_pkg::NTAC_AWAKE && c_loop)
				loop_req <= 1'b1;
			else if (!c_loop && !(state == ntac_pkg::NTAC_AWAKE))
				loop_req <= 1'b0;
			if (c_err)
				tx_transparent_bit <= 1'b0;
			else if (c_sync)
				tx_transparent_bit <= 1'b1;
			rx_open <= (state == ntac_pkg::NTAC_ACTIVE) || do_dt;
			tx_open <= do_dt || (state == ntac_pkg::NTAC_ACTIVE && (far_transparent_bit || loop_req));
			network_wake_tone    <= next_state == ntac_pkg::NTAC_TONE;
			echo_training_signal <= next_state == ntac_pkg::NTAC_TRAIN;
			analog_loop          <= loop_req && c_loop;
			core_clear           <= do_clear;
			iface_clocks_on      <= next_state != ntac_pkg::NTAC_IDLE;
			s_side_enable        <= state == ntac_pkg::NTAC_ACTIVE && line_only_bit;
			if (pin_rst || (c_clr && !pin_any))
				ind_code <= ntac_pkg::MSG_POWER_DOWN;
			else if (pin_sp || up_sp)
				ind_code <= ntac_pkg::MSG_DEACT_REQ;
			else if (next_state == ntac_pkg::NTAC_PEND || next_state == ntac_pkg::NTAC_IDLE)
				ind_code <= ntac_pkg::MSG_DEACT_CONF;
			else if (tx_open)
				ind_code <= ntac_pkg::MSG_ACT_IND;
			else
				ind_code <= ntac_pkg::MSG_POWER_UP;
		end
	end

	// Line-event detectors, counted in ticks except the wake-tone detector, which counts tone periods
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			frame_cnt  <= 16'h0000;
			frame_loss <= 1'b0;
			short_cnt  <= 16'h0000;
			short_run  <= 1'b0;
			short_signal_loss <= 1'b0;
			long_signal_loss  <= 1'b0;
			tone_cnt   <= 4'h0;
			exchange_wake_tone <= 1'b0;
			fill_cnt   <= 16'h0000;
			fill_last  <= 1'b0;
			fill_pattern_detect_zero <= 1'b0;
			fill_pattern_detect_one  <= 1'b0;
		end
		else
		begin
			if (frame_ok)
				frame_cnt <= 16'h0000;
			else if (tick && frame_cnt != 16'(FRAME_TICKS))
				frame_cnt <= frame_cnt + 16'h0001;
			frame_loss <= !frame_ok && (frame_cnt == 16'(FRAME_TICKS) || poor_sync);
			if (line_signal)
				short_cnt <= 16'h0000;
			else if (tick && short_cnt != 16'(ntac_pkg::SHORT_TICKS))
				short_cnt <= short_cnt + 16'h0001;
			short_run <= !line_signal && short_cnt == 16'(ntac_pkg::SHORT_TICKS);
			short_signal_loss <= short_run && expect_silence;
			long_signal_loss  <= long_done || (long_signal_loss && !line_signal);
			if (tone_period && tone_cnt != 4'(ntac_pkg::TONE_PERIODS))
				tone_cnt <= tone_cnt + 4'h1;
			else if (!line_signal)
				tone_cnt <= 4'h0;
			exchange_wake_tone <= tone_cnt == 4'(ntac_pkg::TONE_PERIODS);
			if (fill_bit_valid)
				fill_last <= fill_bit;
			if (!fill_bit_valid || fill_bit != fill_last)
				fill_cnt <= 16'h0000;
			else if (tick && fill_cnt != 16'(ntac_pkg::FILL_TICKS))
				fill_cnt <= fill_cnt + 16'h0001;
			fill_pattern_detect_zero <= fill_cnt == 16'(ntac_pkg::FILL_TICKS) && !fill_last;
			fill_pattern_detect_one  <= fill_cnt == 16'(ntac_pkg::FILL_TICKS) && fill_last;
		end
	end

	// Single pulses: fixed period, width in core cycles
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pulse_cnt <= 16'h0000;
			pulse_w   <= 8'h00;
			single_pulse_out <= 1'b0;
		end
		else
		begin
			if (!do_sp)
				pulse_cnt <= 16'h0000;
			else if (tick)
				pulse_cnt <= (pulse_cnt == 16'(ntac_pkg::PULSE_PER_TICKS - 1)) ? 16'h0000 : pulse_cnt + 16'h0001;
			if (do_sp && tick && pulse_cnt == 16'h0000)
				pulse_w <= 8'(ntac_pkg::PULSE_W_CYCLES);
			else if (pulse_w != 8'h00)
				pulse_w <= pulse_w - 8'h01;
			single_pulse_out <= do_sp && pulse_w != 8'h00;
		end
	end

	ntac_timer #(.WIDTH(24)) u_startup (.core_clk(core_clk), .arst_n(arst_n), .start(t1_start),
		.stop(next_state != ntac_pkg::NTAC_TRAIN), .tick(tick), .count(24'(STARTUP_TICKS)),
		.running(), .done(startup_guard_expired));
	ntac_timer #(.WIDTH(24)) u_echo (.core_clk(core_clk), .arst_n(arst_n),
		.start(state != ntac_pkg::NTAC_TRAIN && next_state == ntac_pkg::NTAC_TRAIN),
		.stop(echo_converged), .tick(tick), .count(24'(ECHO_TICKS)), .running(), .done(echo_guard_expired));
	ntac_timer #(.WIDTH(24)) u_fsync (.core_clk(core_clk), .arst_n(arst_n), .start(frame_loss && !frame_ok),
		.stop(frame_ok), .tick(tick), .count(24'(FSYNC_TICKS)), .running(), .done(fsync_expired));
	ntac_timer #(.WIDTH(24)) u_long (.core_clk(core_clk), .arst_n(arst_n),
		.start(short_run && !expect_silence && !long_signal_loss_arm), .stop(line_signal), .tick(tick),
		.count(24'(LONG_TICKS)), .running(long_signal_loss_arm), .done(long_done));
	ntac_timer #(.WIDTH(24)) u_rxrst (.core_clk(core_clk), .arst_n(arst_n), .start(short_signal_loss),
		.stop(1'b0), .tick(tick), .count(24'(ntac_pkg::RXRST_TICKS)), .running(), .done(rxrst_done));
	ntac_timer #(.WIDTH(24)) u_tone (.core_clk(core_clk), .arst_n(arst_n),
		.start(state != ntac_pkg::NTAC_TONE && next_state == ntac_pkg::NTAC_TONE), .stop(1'b0), .tick(tick),
		.count(24'(ntac_pkg::TONE_TICKS)), .running(), .done(tone_done));
	ntac_timer #(.WIDTH(24)) u_pend (.core_clk(core_clk), .arst_n(arst_n),
		.start(state != ntac_pkg::NTAC_PEND && next_state == ntac_pkg::NTAC_PEND), .stop(1'b0), .tick(tick),
		.count(24'(ntac_pkg::PEND_TICKS)), .running(), .done(pend_done));
endmodule

// >>> hdl/ntac_pkg.sv
/*
 Constants for the NT-side activation criteria block: command codes,
 test-select encodings and all timing figures with their tick counts (pulse width in cycles).
 Assumes a 10 MHz core clock; counts are derived from it.
*/
package ntac_pkg;
	localparam int unsigned CLK_HZ         = 10000000;
	localparam int unsigned TICK_US        = 100;
	localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1000000) * TICK_US;
	localparam int unsigned TICKS_PER_MS   = 1000 / TICK_US;

	localparam int unsigned T_STARTUP_MS   = 15000;
	localparam int unsigned T_ECHO_MS      = 5500;
	localparam int unsigned T_FSYNC_MS     = 15000;
	localparam int unsigned T_RXRST_MS     = 40;
	localparam int unsigned T_TONE_MS      = 9;
	localparam int unsigned T_PEND_US      = 500;
	localparam int unsigned T_FRAME_MS     = 576;
	localparam int unsigned T_SHORT_MS     = 3;
	localparam int unsigned T_LONG_MS      = 588;
	localparam int unsigned T_FILL_MS      = 6;
	localparam int unsigned T_PULSE_PER_US = 1500;
	localparam int unsigned T_PULSE_W_NS   = 12500;
	localparam int unsigned CLK_NS         = 1000000000 / CLK_HZ;

	localparam int unsigned STARTUP_TICKS  = T_STARTUP_MS * TICKS_PER_MS;
	localparam int unsigned ECHO_TICKS     = T_ECHO_MS * TICKS_PER_MS;
	localparam int unsigned FSYNC_TICKS    = T_FSYNC_MS * TICKS_PER_MS;
	localparam int unsigned RXRST_TICKS    = T_RXRST_MS * TICKS_PER_MS;
	localparam int unsigned TONE_TICKS     = T_TONE_MS * TICKS_PER_MS;
	localparam int unsigned PEND_TICKS     = T_PEND_US / TICK_US;
	localparam int unsigned FRAME_TICKS    = T_FRAME_MS * TICKS_PER_MS;
	localparam int unsigned SHORT_TICKS    = T_SHORT_MS * TICKS_PER_MS;
	localparam int unsigned LONG_TICKS     = T_LONG_MS * TICKS_PER_MS;
	localparam int unsigned FILL_TICKS     = T_FILL_MS * TICKS_PER_MS;
	localparam int unsigned PULSE_PER_TICKS = T_PULSE_PER_US / TICK_US;
	localparam int unsigned PULSE_W_CYCLES = (T_PULSE_W_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TONE_PERIODS   = 12;

	localparam logic [3:0] CODE_KEEP_TIMING = 4'h0;
	localparam logic [3:0] CODE_ACT_REQ     = 4'h8;
	localparam logic [3:0] CODE_LOCAL_LOOP  = 4'ha;
	localparam logic [3:0] CODE_DATA_THRU   = 4'h3;
	localparam logic [3:0] CODE_S_SYNC      = 4'hc;
	localparam logic [3:0] CODE_S_ERROR     = 4'h6;
	localparam logic [3:0] CODE_CORE_CLEAR  = 4'h1;
	localparam logic [3:0] CODE_SINGLE_PULSE = 4'h2;
	localparam logic [3:0] CODE_IDLE_DEACT  = 4'hf;

	localparam logic [3:0] MSG_POWER_DOWN   = 4'hf;
	localparam logic [3:0] MSG_DEACT_REQ    = 4'h0;
	localparam logic [3:0] MSG_DEACT_CONF   = 4'hf;
	localparam logic [3:0] MSG_POWER_UP     = 4'h7;
	localparam logic [3:0] MSG_ACT_IND      = 4'hc;

	localparam logic [1:0] TSEL_SINGLE_PULSE = 2'h3;
	localparam logic [1:0] TSEL_DATA_THRU    = 2'h2;

	typedef enum logic [2:0] {
		NTAC_IDLE     = 3'b000,
		NTAC_AWAKE    = 3'b001,
		NTAC_TONE     = 3'b011,
		NTAC_TRAIN    = 3'b010,
		NTAC_ACTIVE   = 3'b110,
		NTAC_TEST     = 3'b111,
		NTAC_PEND     = 3'b101
	} ntac_state_type;
endpackage

// >>> hdl/ntac_timer.sv
/*
 Tick-driven down counter: loads on start, counts ticks, pulses done once.
 Assumes tick is a one-cycle pulse from the shared divider.
*/
`timescale 1ns/1ps
module ntac_timer #(
	parameter int unsigned WIDTH = 24
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic             start,
	input  wire logic             stop,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] count,
	output logic                  running,
	output logic                  done
);
	logic [WIDTH-1:0] remain;
	wire              last = running && tick && (remain == {{(WIDTH-1){1'b0}}, 1'b1});

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			remain  <= '0;
			running <= 1'b0;
			done    <= 1'b0;
		end
		else
		begin
			done <= last;
			if (start)
			begin
				remain  <= count;
				running <= 1'b1;
			end
			else if (stop || last)
				running <= 1'b0;
			else if (running && tick)
				remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule

// >>> testbench/ntac_core_assertions.sv
/*
 Port checker for ntac_core, bound into every instance of it.
 Assumes the tick and long-loss counts are handed on by the bind.
*/
`timescale 1ns/1ps
module ntac_core_assertions #(
	parameter int unsigned TICK_CYCLES = 4,
	parameter int unsigned LONG_TICKS  = 20
) (
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic [3:0] cmd_code,
	input wire logic       cmd_valid,
	input wire logic       reset_pin_n,
	input wire logic       pulse_test_pin,
	input wire logic       up_mode,
	input wire logic       soft_wake_bit,
	input wire logic       test_select_low,
	input wire logic       test_select_high,
	input wire logic       line_signal,
	input wire logic       expect_silence,
	input wire logic       tx_transparent_bit,
	input wire logic       tx_open,
	input wire logic       rx_open,
	input wire logic       single_pulse_out,
	input wire logic       core_clear,
	input wire logic       iface_clocks_on,
	input wire logic [3:0] ind_code,
	input wire logic       short_signal_loss,
	input wire logic       long_signal_loss
);
	localparam int SHORT_LO = (ntac_pkg::SHORT_TICKS - 1) * TICK_CYCLES;
	localparam int SHORT_HI = (ntac_pkg::SHORT_TICKS + 1) * TICK_CYCLES + 2;
	localparam int LONG_HI  = (ntac_pkg::SHORT_TICKS + LONG_TICKS + 1) * TICK_CYCLES + 2;
	logic [31:0] lost_cnt;
	logic [31:0] next_lost_cnt;
	wire         pins_free;
	wire         pin_reset;
	// Tick phase is unknown, so loss windows allow one tick either side
	assign next_lost_cnt = line_signal ? 32'h0000_0000 : lost_cnt + 32'h0000_0001;
	assign pin_reset     = !reset_pin_n && !(pulse_test_pin && !up_mode);
	assign pins_free     = reset_pin_n && !(pulse_test_pin && !up_mode) && !(up_mode && test_select_high);
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			lost_cnt <= 32'h0000_0000;
		else
			lost_cnt <= next_lost_cnt;
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	sequence cmd_s(logic [3:0] c);
		cmd_valid && cmd_code == c && pins_free;
	endsequence
	sequence pin_reset_s;
		(pin_reset && !up_mode) [*3];
	endsequence
	sync_sets_bit_a: assert property (cmd_s(ntac_pkg::CODE_S_SYNC) |=> tx_transparent_bit)
		else $error("sync indication left transparency bit low");
	clear_cmd_core_a: assert property (cmd_s(ntac_pkg::CODE_CORE_CLEAR) |=> core_clear)
		else $error("clear command did not clear the core");
	pin_reset_msg_a: assert property (pin_reset |=> core_clear && ind_code == ntac_pkg::MSG_POWER_DOWN)
		else $error("reset pin gave no core clear or power-down message");
	pulse_pin_msg_a: assert property (!up_mode && pulse_test_pin && reset_pin_n |=> ind_code == 4'h0)
		else $error("pulse test pin gave no deactivation request");
	tsel_through_a: assert property (up_mode && !test_select_low && test_select_high && reset_pin_n
		|=> tx_open && rx_open)
		else $error("through select did not open both directions");
	pin_priority_a: assert property (pin_reset_s |-> !tx_open && !single_pulse_out)
		else $error("channel test ran under reset pin");
	soft_wake_a: assert property (up_mode && !soft_wake_bit && pins_free |-> ##[1:3] iface_clocks_on)
		else $error("cleared soft wake did not start clocks");
	short_late_a: assert property (expect_silence && lost_cnt > SHORT_HI |-> short_signal_loss)
		else $error("short signal loss late");
	short_early_a: assert property (expect_silence && lost_cnt >= 3 && lost_cnt <= SHORT_LO
		|-> !short_signal_loss)
		else $error("short signal loss early");
	long_late_a: assert property (!expect_silence && lost_cnt > LONG_HI |-> long_signal_loss)
		else $error("long signal loss late");
endmodule

bind ntac_core ntac_core_assertions #(.TICK_CYCLES(TICK_CYCLES), .LONG_TICKS(LONG_TICKS)) i_chk (
	.core_clk, .arst_n, .cmd_code, .cmd_valid, .reset_pin_n, .pulse_test_pin, .up_mode, .soft_wake_bit,
	.test_select_low, .test_select_high, .line_signal, .expect_silence, .tx_transparent_bit, .tx_open,
	.rx_open, .single_pulse_out, .core_clear, .iface_clocks_on, .ind_code, .short_signal_loss,
	.long_signal_loss);

// >>> testbench/ntac_far_model.sv
/*
 Far-side model: local controller channel and line wake-tone source.
 Assumes bench requests change just after the clock edge.
*/
`timescale 1ns/1ps
module ntac_far_model #(
	parameter int unsigned TONE_CYCLES = 1000
) (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] req_code,
	input  wire logic       req_valid,
	input  wire logic       deact_go,
	input  wire logic [4:0] tone_req,
	input  wire logic       tone_go,
	output logic [3:0]      cmd_code,
	output logic            cmd_valid,
	output logic            tone_period
);
	logic [15:0] phase;
	logic [4:0]  left;
	wire         wrap;
	// Idle code held for the whole teardown; channel rests at all ones
	assign cmd_code  = deact_go ? ntac_pkg::CODE_IDLE_DEACT : (req_valid ? req_code : 4'hf);
	assign cmd_valid = deact_go | req_valid;
	assign wrap      = (left != 5'h00) && (phase == 16'(TONE_CYCLES - 1));
	// One pulse per 10 kHz period, a run of tone_req of them
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase       <= 16'h0000;
			left        <= 5'h00;
			tone_period <= 1'h0;
		end
		else
		begin
			phase       <= (tone_go || wrap) ? 16'h0000 : phase + 16'h0001;
			left        <= tone_go ? tone_req : left - {4'h0, wrap};
			tone_period <= wrap;
		end
	end
endmodule

// >>> testbench/tb_ntac_core.sv
/*
 Bench for ntac_core: table of command and pin cases, then timing cases.
 Assumes the far-side model and the bound checker; counts are reduced.
*/
`timescale 1ns/1ps
module tb_ntac_core;
	localparam int TICK = 20;
	localparam int CNT  = 20;
	typedef struct packed {logic [3:0] code; logic [5:0] pins; logic [3:0] sel; logic [3:0] exp;} ntac_row_type;
	localparam ntac_row_type ROWS [11] = '{
		'{ntac_pkg::CODE_S_SYNC, 6'h30, 4'h1, 4'h1},
		'{ntac_pkg::CODE_S_ERROR, 6'h30, 4'h1, 4'h0},
		'{ntac_pkg::CODE_CORE_CLEAR, 6'h30, 4'h2, 4'h1},
		'{ntac_pkg::CODE_SINGLE_PULSE, 6'h30, 4'h2, 4'h0},
		'{ntac_pkg::CODE_DATA_THRU, 6'h30, 4'h3, 4'h1},
		'{ntac_pkg::CODE_DATA_THRU, 6'h20, 4'h3, 4'h0},
		'{ntac_pkg::CODE_CORE_CLEAR, 6'h38, 4'h2, 4'h0},
		'{4'h0, 6'h00, 4'h2, 4'h1},
		'{4'h0, 6'h18, 4'h0, ntac_pkg::MSG_DEACT_REQ},
		'{4'h0, 6'h17, 4'h0, ntac_pkg::MSG_DEACT_REQ},
		'{4'h0, 6'h15, 4'h3, 4'h1}
	};
	logic       core_clk = 1'h0;
	logic       arst_n   = 1'h0;
	logic [3:0] req_code, cmd_code, ind_code;
	logic [4:0] tone_req;
	logic       req_valid, deact_go, tone_go, cmd_valid, tone_period, data_in_pin, reset_pin_n, pulse_test_pin;
	logic       up_mode, soft_wake_bit, test_select_low, test_select_high, far_transparent_bit, teardown_bit;
	logic       line_only_bit, line_signal, frame_ok, poor_sync, fill_bit_valid, fill_bit, echo_converged;
	logic       expect_silence, tx_transparent_bit, tx_open, rx_open, network_wake_tone, echo_training_signal;
	logic       analog_loop, single_pulse_out, core_clear, iface_clocks_on, s_side_enable, frame_loss;
	logic       short_signal_loss, long_signal_loss, exchange_wake_tone, fill_pattern_detect_zero;
	logic       fill_pattern_detect_one, startup_guard_expired, tone_done;
	int         mismatches = 0, samples_checked = 0, n, m;
	always #50 core_clk = ~core_clk;
	ntac_far_model i_far (.core_clk, .arst_n, .req_code, .req_valid, .deact_go, .tone_req, .tone_go, .cmd_code,
		.cmd_valid, .tone_period);
	ntac_core #(.TICK_CYCLES(TICK), .STARTUP_TICKS(CNT), .ECHO_TICKS(CNT), .FSYNC_TICKS(CNT),
		.LONG_TICKS(CNT), .FRAME_TICKS(CNT)) i_dut (.core_clk, .arst_n, .cmd_code, .cmd_valid, .data_in_pin,
		.reset_pin_n, .pulse_test_pin, .up_mode, .soft_wake_bit, .test_select_low, .test_select_high,
		.far_transparent_bit, .teardown_bit, .line_only_bit, .line_signal, .frame_ok, .poor_sync, .tone_period,
		.fill_bit_valid, .fill_bit, .echo_converged, .expect_silence, .tx_transparent_bit, .tx_open, .rx_open,
		.network_wake_tone, .echo_training_signal, .analog_loop, .single_pulse_out, .core_clear,
		.iface_clocks_on, .s_side_enable, .ind_code, .frame_loss, .short_signal_loss, .long_signal_loss,
		.exchange_wake_tone, .fill_pattern_detect_zero, .fill_pattern_detect_one, .startup_guard_expired,
		.echo_guard_expired(), .fsync_expired(), .rxrst_done(), .tone_done, .pend_done());
	function automatic logic [3:0] obs(input int s);
		logic [15:0] v;
		v = {startup_guard_expired, tone_done, fill_pattern_detect_one, fill_pattern_detect_zero,
			exchange_wake_tone, frame_loss, long_signal_loss, short_signal_loss, single_pulse_out,
			analog_loop, echo_training_signal, network_wake_tone, iface_clocks_on, tx_open & rx_open,
			core_clear, tx_transparent_bit};
		return (s == 0) ? ind_code : {3'h0, v[s-1]};
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic await(input int s, input logic [3:0] v, input int lim, output int k);
		k = 0;
		while (obs(s) !== v && k < lim)
		begin
			tick(1);
			k++;
		end
	endtask
	task automatic check_val(input logic [3:0] got, input logic [3:0] exp, input string msg);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic check_count(input int k, input int lo, input int hi, input string msg);
		samples_checked++;
		if (k < lo || k > hi)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s count %0d outside %0d..%0d", $time, msg, k, lo, hi);
		end
	endtask
	task automatic do_reset();
		{req_code, tone_req, req_valid, deact_go, tone_go, pulse_test_pin, up_mode} = 14'h0000;
		{test_select_low, test_select_high, far_transparent_bit, line_only_bit, poor_sync} = 5'h00;
		{fill_bit_valid, fill_bit, echo_converged, expect_silence} = 4'h0;
		{data_in_pin, reset_pin_n, soft_wake_bit, teardown_bit, line_signal, frame_ok} = 6'h3f;
		arst_n = 1'h0;
		tick(4);
		arst_n = 1'h1;
		tick(1);
	endtask
	task automatic end_sim();
		$display("Mismatches %0d, comparisons %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#(60000 * 100);
		mismatches++;
		end_sim();
	end
	initial
	begin
		foreach (ROWS[i])
		begin
			do_reset();
			{req_valid, reset_pin_n, pulse_test_pin, up_mode, test_select_low, test_select_high} = ROWS[i].pins;
			req_code = ROWS[i].code;
			tick(3);
			check_val(obs(ROWS[i].sel), ROWS[i].exp, "table row");
		end
		do_reset();
		data_in_pin = 1'h0;
		await(4, 4'h1, 50, n);
		check_count(n, 0, 3, "wake by data pin");
		{data_in_pin, req_valid, req_code} = {2'h3, ntac_pkg::CODE_KEEP_TIMING};
		tick(20);
		check_val(obs(4), 4'h1, "clocks kept");
		req_code = ntac_pkg::CODE_S_SYNC;
		tick(1);
		req_code = ntac_pkg::CODE_S_ERROR;
		tick(1);
		check_val(obs(1), 4'h0, "error bit");
		req_code = ntac_pkg::CODE_ACT_REQ;
		tick(2);
		check_val(obs(5), 4'h1, "network tone");
		await(15, 4'h1, 2000, n);
		check_count(n, (ntac_pkg::TONE_TICKS - 1) * TICK, (ntac_pkg::TONE_TICKS + 1) * TICK + 2, "tone time");
		tick(2);
		check_val(obs(6), 4'h1, "training after tone");
		do_reset();
		data_in_pin = 1'h0;
		tick(5);
		{data_in_pin, deact_go} = 2'h3;
		await(4, 4'h0, 8000, n);
		check_count(n, 1, 7999, "clocks off after idle code");
		do_reset();
		{up_mode, soft_wake_bit} = 2'h2;
		await(4, 4'h1, 50, n);
		check_count(n, 0, 3, "soft wake");
		do_reset();
		{req_valid, req_code} = {1'h1, ntac_pkg::CODE_LOCAL_LOOP};
		tick(3);
		check_val(obs(7) & obs(6), 4'h1, "analog loop training");
		await(16, 4'h1, 2 * CNT * TICK, n);
		check_count(n, 2 * CNT * TICK, 2 * CNT * TICK, "no start-up guard");
		do_reset();
		{req_valid, req_code} = {1'h1, ntac_pkg::CODE_SINGLE_PULSE};
		await(8, 4'h1, 400, n);
		await(8, 4'h0, 200, n);
		check_count(n, 125, 125, "pulse width");
		await(8, 4'h1, 400, m);
		check_count(n + m, ntac_pkg::PULSE_PER_TICKS * TICK - 1, ntac_pkg::PULSE_PER_TICKS * TICK + 1, "period");
		do_reset();
		frame_ok = 1'h0;
		await(11, 4'h1, 2000, n);
		check_count(n, 0, (CNT + 1) * TICK + 2, "frame loss");
		{frame_ok, expect_silence, line_signal} = 3'h6;
		await(9, 4'h1, 2000, n);
		check_count(n, (ntac_pkg::SHORT_TICKS - 1) * TICK, (ntac_pkg::SHORT_TICKS + 1) * TICK + 2, "short");
		{expect_silence, line_signal} = 2'h1;
		tick(5);
		line_signal = 1'h0;
		await(10, 4'h1, 2000, n);
		check_count(n, (ntac_pkg::SHORT_TICKS + CNT - 2) * TICK,
			(ntac_pkg::SHORT_TICKS + CNT + 1) * TICK + 2, "long loss");
		for (int k = 11; k <= 12; k++)
		begin
			do_reset();
			{tone_req, tone_go} = {5'(k), 1'h1};
			tick(1);
			tone_go = 1'h0;
			await(12, 4'h1, 13000, n);
			check_count(n, (k == 12) ? 11990 : 13000, (k == 12) ? 12010 : 13000, "exchange tone");
		end
		for (int b = 0; b < 2; b++)
		begin
			do_reset();
			{fill_bit_valid, fill_bit} = {1'h1, 1'(b)};
			await(13 + b, 4'h1, 3000, n);
			check_count(n, (ntac_pkg::FILL_TICKS - 1) * TICK, 2 * ntac_pkg::FILL_TICKS * TICK + 2, "fill");
		end
		end_sim();
	end
endmodule
